// ==== rtl/rfp_regs.sv ====
// Behaviour
// [R01] User program base in RAM reads zero in bits 31..16 and stores nothing there.
// [R02] Bits 15..10 of the RAM user program base are writable and set the user program start.
// [R03] Bits 9..0 of the RAM user program base always read zero, giving 1 KB steps.
// [R04] Software keeps the RAM user program base above the RAM user data base.
// [R05] Reset forces both user program bases to zero, leaving all RAM to kernel data.
// [R06] Software keeps the RAM user program base at or below the reported RAM size.
// [R07] The RAM size register is read-only and returns a fixed valid byte count.
// [R08] User program base in flash reads zero in bits 31..20 and stores nothing there.
// [R09] Bits 19..11 of the flash user program base are writable and set the region start.
// [R10] Bits 10..0 of the flash user program base always read zero, giving 2 KB steps.
// [R11] Software keeps the flash user program base at or below the reported flash size.
// [R12] The flash size register is read-only and returns a fixed valid byte count.
// [R13] Software keeps the RAM user data base above the RAM kernel program base.
// [R14] Writes to read-only or unimplemented bits, and to the size registers, are ignored.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module rfp_regs import rfp_pkg::*; #(
    parameter logic [31:0] RAM_SIZE = RFP_RAM_SZ_8K,
    parameter logic [31:0] FLASH_SIZE = RFP_FL_SZ_32K
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [RFP_AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    input wire logic [15:0] RAM_USER_DATA_BASE_IN,
    input wire logic [15:0] RAM_KERNEL_PROGRAM_BASE_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic [15:0] RAM_USER_PROGRAM_BASE_OUT,
    output logic [19:0] FLASH_USER_PROGRAM_BASE_OUT,
    output logic [RFP_ST_W-1:0] PARTITION_STATUS_OUT,
    output logic PARTITION_FAULT_OUT
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    rfp_apb_state_e state;
    rfp_apb_state_e next_state;
    logic [5:0] ram_field;
    logic [8:0] flash_field;
    logic [15:0] ram_base;
    logic [19:0] flash_base;
    logic [31:0] next_rdata;
    logic access;
    logic wr_fire;
    logic rd_fire;

    rfp_part_if part ();

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign access = PSEL_IN && PENABLE_IN;
    assign wr_fire = access && PREADY_OUT && PWRITE_IN;
    assign rd_fire = access && PREADY_OUT && !PWRITE_IN;

    // only the stored fields exist; the rest is wired zero
    assign ram_base = {ram_field, 10'h000}; // [R03]
    assign flash_base = {flash_field, 11'h000}; // [R10]

    // ----------------------------------------------------------------
    // apb handshake, one wait state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            RFP_APB_IDLE: begin
                if (access) begin
                    next_state = RFP_APB_ANSWER;
                end
            end
            RFP_APB_ANSWER: begin
                next_state = RFP_APB_IDLE;
            end
            default: begin
                next_state = RFP_APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state <= RFP_APB_IDLE;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            state <= next_state;
            PREADY_OUT <= (state == RFP_APB_IDLE) && access;
            PSLVERR_OUT <= (state == RFP_APB_IDLE) && access && !rfp_reg_hit(PADDR_IN);
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        case (PADDR_IN)
            RFP_OFS_RAM_UPB: begin
                next_rdata = {16'h0000, ram_base}; // [R01]
            end
            RFP_OFS_RAM_SIZE: begin
                next_rdata = RAM_SIZE; // [R07]
            end
            RFP_OFS_FLASH_UPB: begin
                next_rdata = {12'h000, flash_base}; // [R08]
            end
            RFP_OFS_FLASH_SIZE: begin
                next_rdata = FLASH_SIZE; // [R12]
            end
            RFP_OFS_STATUS: begin
                next_rdata = {27'h0000000, part.status};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if ((state == RFP_APB_IDLE) && access && !PWRITE_IN) begin
            PRDATA_OUT <= next_rdata;
        end else begin
            PRDATA_OUT <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // user program base in data ram
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ram_field <= RFP_RAM_RST; // [R05]
        end else if (wr_fire && (PADDR_IN == RFP_OFS_RAM_UPB) && PSTRB_IN[1]) begin
            ram_field <= PWDATA_IN[RFP_RAM_MSB:RFP_RAM_LSB]; // [R02] [R14]
        end
    end

    // ----------------------------------------------------------------
    // user program base in program flash
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            flash_field <= RFP_FL_RST; // [R05]
        end else if (wr_fire && (PADDR_IN == RFP_OFS_FLASH_UPB)) begin
            if (PSTRB_IN[1]) begin
                flash_field[4:0] <= PWDATA_IN[RFP_FL_SPLIT-1:RFP_FL_LSB]; // [R09] [R14]
            end
            if (PSTRB_IN[2]) begin
                flash_field[8:5] <= PWDATA_IN[RFP_FL_MSB:RFP_FL_SPLIT]; // [R09] [R14]
            end
        end
    end

    // ----------------------------------------------------------------
    // partition check
    // ----------------------------------------------------------------
    assign part.ram_base = ram_base;
    assign part.flash_base = flash_base;
    assign part.ram_size = RAM_SIZE;
    assign part.flash_size = FLASH_SIZE;
    assign part.user_data_base = RAM_USER_DATA_BASE_IN;
    assign part.kernel_base = RAM_KERNEL_PROGRAM_BASE_IN;

    rfp_check u_check (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .part(part.chk)
    );

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            RAM_USER_PROGRAM_BASE_OUT <= 16'h0000;
            FLASH_USER_PROGRAM_BASE_OUT <= 20'h00000;
            PARTITION_STATUS_OUT <= '0;
            PARTITION_FAULT_OUT <= 1'b0;
        end else begin
            RAM_USER_PROGRAM_BASE_OUT <= ram_base;
            FLASH_USER_PROGRAM_BASE_OUT <= flash_base;
            PARTITION_STATUS_OUT <= part.status;
            PARTITION_FAULT_OUT <= |part.status;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_RAM_HIGH_ZERO: assert property ( // [R01]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_RAM_UPB) |-> PRDATA_OUT[31:16] == 16'h0000
    ) else $error("ram user base upper bits not zero");

    AST_RAM_FIELD_WRITE: assert property ( // [R02]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN == RFP_OFS_RAM_UPB) && PSTRB_IN[1]
        |-> ##2 RAM_USER_PROGRAM_BASE_OUT[15:10] == $past(PWDATA_IN[15:10], 2)
    ) else $error("ram user base write not applied");

    AST_RAM_LOW_ZERO: assert property ( // [R03]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_RAM_UPB) |-> PRDATA_OUT[9:0] == 10'h000
    ) else $error("ram user base low bits not zero");

    AST_RESET_CLEARS: assert property ( // [R05]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(RST_N_IN) |-> (ram_field == 6'h00) && (flash_field == 9'h000)
            ##1 (RAM_USER_PROGRAM_BASE_OUT == 16'h0000)
    ) else $error("bases not cleared by reset");

    AST_RAM_SIZE_READ: assert property ( // [R07]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_RAM_SIZE) |-> PRDATA_OUT == RAM_SIZE && !PSLVERR_OUT
    ) else $error("ram size read wrong");

    AST_FLASH_HIGH_ZERO: assert property ( // [R08]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_FLASH_UPB) |-> PRDATA_OUT[31:20] == 12'h000
    ) else $error("flash user base upper bits not zero");

    AST_FLASH_FIELD_WRITE: assert property ( // [R09]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN == RFP_OFS_FLASH_UPB) && (PSTRB_IN[2:1] == 2'b11)
        |-> ##2 FLASH_USER_PROGRAM_BASE_OUT[19:11] == $past(PWDATA_IN[19:11], 2)
    ) else $error("flash user base write not applied");

    AST_FLASH_LOW_ZERO: assert property ( // [R10]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_FLASH_UPB) |-> PRDATA_OUT[10:0] == 11'h000
    ) else $error("flash user base low bits not zero");

    AST_FLASH_SIZE_READ: assert property ( // [R12]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_FLASH_SIZE) |-> PRDATA_OUT == FLASH_SIZE
    ) else $error("flash size read wrong");

    AST_RO_WRITE_IGNORED: assert property ( // [R14]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN != RFP_OFS_RAM_UPB) && (PADDR_IN != RFP_OFS_FLASH_UPB)
        |=> $stable(ram_field) && $stable(flash_field)
    ) else $error("write to read-only register changed a base");

    AST_READY_ONE_WAIT: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state == RFP_APB_IDLE) && access |=> PREADY_OUT ##1 !PREADY_OUT
    ) else $error("ready not one cycle after one wait state");

    AST_UNMAPPED_ERROR: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state == RFP_APB_IDLE) && access && !rfp_reg_hit(PADDR_IN)
        |=> PREADY_OUT && PSLVERR_OUT && (PRDATA_OUT == 32'h0000_0000)
    ) else $error("unmapped access not answered with an error");

    AST_MAPPED_NO_ERROR: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state == RFP_APB_IDLE) && access && rfp_reg_hit(PADDR_IN)
        |=> PREADY_OUT && !PSLVERR_OUT
    ) else $error("mapped access answered with an error");

    AST_RAM_STROBE_OFF: assert property ( // [R14]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN == RFP_OFS_RAM_UPB) && !PSTRB_IN[1] |=> $stable(ram_field)
    ) else $error("ram user base changed without its lane");

    AST_FLASH_LANE_KEEP: assert property ( // [R14]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN == RFP_OFS_FLASH_UPB) && !PSTRB_IN[2] |=> $stable(flash_field[8:5])
    ) else $error("flash user base upper field changed without its lane");

    AST_RAM_OUT_FOLLOWS: assert property ( // [R02] [R03]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (RAM_USER_PROGRAM_BASE_OUT == $past(ram_base)) && (RAM_USER_PROGRAM_BASE_OUT[9:0] == 10'h000)
    ) else $error("ram user base output does not follow the register");

    AST_FLASH_OUT_FOLLOWS: assert property ( // [R09] [R10]
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (FLASH_USER_PROGRAM_BASE_OUT == $past(flash_base)) &&
        (FLASH_USER_PROGRAM_BASE_OUT[10:0] == 11'h000)
    ) else $error("flash user base output does not follow the register");

    AST_STATUS_FOLLOWS: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        PARTITION_STATUS_OUT == $past(part.status)
    ) else $error("partition status output does not follow the flags");

    AST_FAULT_FOLLOWS: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        PARTITION_FAULT_OUT == |$past(part.status)
    ) else $error("partition fault output does not follow the flags");

    AST_STATUS_READ: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_STATUS)
        |-> PRDATA_OUT == {27'h0000000, $past(part.status)}
    ) else $error("partition status read wrong");

    COV_RAM_WRITE: cover property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_fire && (PADDR_IN == RFP_OFS_RAM_UPB) && (PWDATA_IN[15:10] != 6'h00)
    );
    COV_FLASH_READ: cover property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        rd_fire && (PADDR_IN == RFP_OFS_FLASH_UPB) && (PRDATA_OUT != 32'h0000_0000)
    );
    COV_UNMAPPED: cover property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        PREADY_OUT && PSLVERR_OUT
    );
    COV_FAULT: cover property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(PARTITION_FAULT_OUT)
    );

endmodule : rfp_regs

// ==== rtl/rfp_pkg.sv ====
package rfp_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int RFP_AW = 12;
    localparam logic [11:0] RFP_OFS_RAM_UPB = 12'h000;
    localparam logic [11:0] RFP_OFS_RAM_SIZE = 12'h004;
    localparam logic [11:0] RFP_OFS_FLASH_UPB = 12'h008;
    localparam logic [11:0] RFP_OFS_FLASH_SIZE = 12'h00c;
    localparam logic [11:0] RFP_OFS_STATUS = 12'h010;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int RFP_RAM_LSB = 10;
    localparam int RFP_RAM_MSB = 15;
    localparam int RFP_FL_LSB = 11;
    localparam int RFP_FL_MSB = 19;
    localparam int RFP_FL_SPLIT = 16;
    localparam logic [5:0] RFP_RAM_RST = 6'h00;
    localparam logic [8:0] RFP_FL_RST = 9'h000;

    // ----------------------------------------------------------------
    // implemented sizes in bytes
    // ----------------------------------------------------------------
    localparam logic [31:0] RFP_RAM_SZ_4K = 32'h0000_1000;
    localparam logic [31:0] RFP_RAM_SZ_8K = 32'h0000_2000;
    localparam logic [31:0] RFP_RAM_SZ_16K = 32'h0000_4000;
    localparam logic [31:0] RFP_RAM_SZ_32K = 32'h0000_8000;
    localparam logic [31:0] RFP_RAM_SZ_64K = 32'h0001_0000;
    localparam logic [31:0] RFP_FL_SZ_16K = 32'h0000_4000;
    localparam logic [31:0] RFP_FL_SZ_32K = 32'h0000_8000;
    localparam logic [31:0] RFP_FL_SZ_64K = 32'h0001_0000;
    localparam logic [31:0] RFP_FL_SZ_128K = 32'h0002_0000;
    localparam logic [31:0] RFP_FL_SZ_256K = 32'h0004_0000;

    // ----------------------------------------------------------------
    // partition status bits
    // ----------------------------------------------------------------
    localparam int RFP_ST_W = 5;
    localparam int RFP_ST_RAM_OVER = 0;
    localparam int RFP_ST_RAM_ORDER = 1;
    localparam int RFP_ST_DATA_ORDER = 2;
    localparam int RFP_ST_FL_OVER = 3;
    localparam int RFP_ST_SIZE_BAD = 4;

    typedef enum logic [0:0] {
        RFP_APB_IDLE,
        RFP_APB_ANSWER
    } rfp_apb_state_e;

    function automatic logic rfp_reg_hit(input logic [11:0] a);
        return (a == RFP_OFS_RAM_UPB) || (a == RFP_OFS_RAM_SIZE) ||
               (a == RFP_OFS_FLASH_UPB) || (a == RFP_OFS_FLASH_SIZE) ||
               (a == RFP_OFS_STATUS);
    endfunction : rfp_reg_hit

    function automatic logic rfp_ram_size_ok(input logic [31:0] s);
        return (s == RFP_RAM_SZ_4K) || (s == RFP_RAM_SZ_8K) || (s == RFP_RAM_SZ_16K) ||
               (s == RFP_RAM_SZ_32K) || (s == RFP_RAM_SZ_64K);
    endfunction : rfp_ram_size_ok

    function automatic logic rfp_fl_size_ok(input logic [31:0] s);
        return (s == RFP_FL_SZ_16K) || (s == RFP_FL_SZ_32K) || (s == RFP_FL_SZ_64K) ||
               (s == RFP_FL_SZ_128K) || (s == RFP_FL_SZ_256K);
    endfunction : rfp_fl_size_ok

endpackage : rfp_pkg

// ==== rtl/rfp_part_if.sv ====
`timescale 1ns/1ps
interface rfp_part_if import rfp_pkg::*; ();
    logic [15:0] ram_base;
    logic [19:0] flash_base;
    logic [31:0] ram_size;
    logic [31:0] flash_size;
    logic [15:0] user_data_base;
    logic [15:0] kernel_base;
    logic [RFP_ST_W-1:0] status;

    modport regs (
        output ram_base, flash_base, ram_size, flash_size, user_data_base, kernel_base,
        input status
    );
    modport chk (
        input ram_base, flash_base, ram_size, flash_size, user_data_base, kernel_base,
        output status
    );
endinterface : rfp_part_if

// ==== rtl/rfp_check.sv ====
`timescale 1ns/1ps
module rfp_check import rfp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    rfp_part_if.chk part
);

    // ----------------------------------------------------------------
    // partition consistency flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            part.status <= '0;
        end else begin
            part.status[RFP_ST_RAM_OVER] <= {16'h0000, part.ram_base} > part.ram_size; // [R06]
            part.status[RFP_ST_RAM_ORDER] <= (part.ram_base != 16'h0000) &&
                (part.ram_base <= part.user_data_base); // [R04]
            part.status[RFP_ST_DATA_ORDER] <= (part.user_data_base != 16'h0000) &&
                (part.user_data_base <= part.kernel_base); // [R13]
            part.status[RFP_ST_FL_OVER] <= {12'h000, part.flash_base} > part.flash_size; // [R11]
            part.status[RFP_ST_SIZE_BAD] <= !rfp_ram_size_ok(part.ram_size) ||
                !rfp_fl_size_ok(part.flash_size);
        end
    end

endmodule : rfp_check

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import rfp_pkg::*; ;
    localparam logic [31:0] T_RAM = RFP_RAM_SZ_16K;
    localparam logic [31:0] T_FL = RFP_FL_SZ_128K;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] udb = 16'h0;
    logic [15:0] kb = 16'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] rub;
    logic [19:0] fub;
    logic [RFP_ST_W-1:0] st;
    logic flt;
    logic [31:0] seed = 32'h0000_3fa5;
    logic [15:0] m_ram = 16'h0;
    logic [19:0] m_fl = 20'h0;
    int mismatches = 0;
    int checks_done = 0;

    rfp_regs #(.RAM_SIZE(T_RAM), .FLASH_SIZE(T_FL)) i_rfp_regs (
        .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .RAM_USER_DATA_BASE_IN(udb), .RAM_KERNEL_PROGRAM_BASE_IN(kb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .RAM_USER_PROGRAM_BASE_OUT(rub), .FLASH_USER_PROGRAM_BASE_OUT(fub),
        .PARTITION_STATUS_OUT(st), .PARTITION_FAULT_OUT(flt)
    );

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [4:0] exp_st(logic [15:0] r, logic [19:0] f, logic [15:0] u,
                                          logic [15:0] k);
        return {1'b0, {12'h0, f} > T_FL, (u != 16'h0) && (u <= k),
                (r != 16'h0) && (r <= u), {16'h0, r} > T_RAM};
    endfunction : exp_st

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one transfer, entered just after a rising edge, one idle cycle after
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    function automatic logic [31:0] exp_rd(logic [11:0] a);
        case (a)
            RFP_OFS_RAM_UPB: return {16'h0, m_ram};
            RFP_OFS_FLASH_UPB: return {12'h0, m_fl};
            RFP_OFS_RAM_SIZE: return T_RAM;
            default: return T_FL;
        endcase
    endfunction : exp_rd

    task automatic rd_chk(input logic [11:0] a);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, 4'h0, rd, err);
        check(rd, exp_rd(a));
        check({31'h0, err}, 32'h0);
    endtask : rd_chk

    task automatic reset_chk();
        logic [11:0] ofs [4];
        ofs = '{RFP_OFS_RAM_UPB, RFP_OFS_RAM_SIZE, RFP_OFS_FLASH_UPB, RFP_OFS_FLASH_SIZE};
        m_ram = 16'h0;
        m_fl = 20'h0;
        check({16'h0, rub}, 32'h0);
        check({12'h0, fub}, 32'h0);
        foreach (ofs[i]) begin
            rd_chk(ofs[i]);
        end
    endtask : reset_chk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] rd;
        logic [31:0] r;
        logic [3:0] s;
        logic [11:0] a;
        logic err;
        logic [11:0] bad [3];
        logic [11:0] tgt [4];
        bad = '{12'h014, 12'h001, 12'hffc};
        tgt = '{RFP_OFS_RAM_UPB, RFP_OFS_FLASH_UPB, RFP_OFS_RAM_SIZE, RFP_OFS_FLASH_SIZE};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_chk();
        for (int i = 0; i < 48; i++) begin
            d = rnd();
            r = rnd();
            s = r[3:0];
            a = tgt[i % 4];
            if (i < 4) begin
                d = 32'hffff_ffff;
                s = 4'hf;
            end else if (i < 8) begin
                d = 32'h0000_03ff;
            end
            r = rnd();
            udb <= r[15:0];
            r = rnd();
            kb <= r[15:0];
            apb(1'b1, a, d, s, rd, err);
            check({31'h0, err}, 32'h0);
            if (a == RFP_OFS_RAM_UPB && s[1]) begin
                m_ram = d[15:0] & 16'hfc00;
            end
            if (a == RFP_OFS_FLASH_UPB) begin
                m_fl = {s[2] ? d[19:16] : m_fl[19:16], s[1] ? d[15:11] : m_fl[15:11], 11'h0};
            end
            rd_chk(a);
            check({16'h0, rub}, {16'h0, m_ram});
            check({12'h0, fub}, {12'h0, m_fl});
            check({27'h0, st}, {27'h0, exp_st(m_ram, m_fl, udb, kb)});
            check({31'h0, flt}, {31'h0, |exp_st(m_ram, m_fl, udb, kb)});
            apb(1'b0, RFP_OFS_STATUS, 32'h0, 4'h0, rd, err);
            check(rd, {27'h0, exp_st(m_ram, m_fl, udb, kb)});
            check({31'h0, err}, 32'h0);
        end
        foreach (bad[i]) begin
            apb(1'b1, bad[i], 32'hffff_ffff, 4'hf, rd, err);
            check({31'h0, err}, 32'h1);
            apb(1'b0, bad[i], 32'h0, 4'h0, rd, err);
            check({31'h0, err}, 32'h1);
            check(rd, 32'h0);
            check({16'h0, rub}, {16'h0, m_ram});
            check({12'h0, fub}, {12'h0, m_fl});
        end
        apb(1'b1, RFP_OFS_RAM_UPB, 32'h0000_fc00, 4'hf, rd, err);
        apb(1'b1, RFP_OFS_FLASH_UPB, 32'h000f_f800, 4'hf, rd, err);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_chk();
        conclude();
    end
endmodule : tb_top
